/* src/fpv_ctrl.sv */
// fixed-priority vectored interrupt controller with ahb-lite register port
`timescale 1ns/1ps
module fpv_ctrl (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // cpu and sources
    input  wire fpv_pkg::fpv_cpu_s cpu,
    input  wire fpv_pkg::fpv_src_s src,
    output fpv_pkg::fpv_seq_s      seq,
    output logic [7:0]             processor_status
);
    localparam int N = fpv_pkg::NSRC;

    logic [N-1:0]             req_reg;
    logic [N-1:0]             ena_reg;
    logic [fpv_pkg::CFG_W-1:0] cfg_reg;
    logic [7:0]               stat_reg;
    logic                     brk_pend_reg;
    fpv_pkg::fpv_state_e      st_reg;
    logic [4:0]               slot_reg;
    logic [N-1:0]             ev;
    logic [N-1:0]             valid_src;
    logic [N-1:0]             pend;
    logic [N-1:0]             win_onehot;
    logic [4:0]               win_slot;
    logic                     any_pend;
    logic                     take_mask;
    logic                     take_brk;
    logic [15:0]              vec_lo;

    // edge detectors: previous levels and an arm flag against a false first edge
    logic [4:0] pin_prev_reg;
    logic       key_prev_reg;
    logic       armed_reg;
    logic [4:0] pin_now;
    logic [4:0] edge_sel;
    logic [4:0] pin_edge;
    logic       key_and;
    logic       key_fall;

    // ahb address-phase capture
    logic       ph_wr_reg;
    logic [7:0] ph_addr_reg;
    logic       ph_valid;
    logic       wr_req;
    logic       wr_ena;
    logic       wr_cfg;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign processor_status = stat_reg;

    assign pin_now  = {src.counter_input_one, src.counter_input_zero,
                       src.ext_irq_two, src.ext_irq_one, src.ext_irq_zero};
    assign edge_sel = {cfg_reg[fpv_pkg::CFG_EDGE_CNT1], cfg_reg[fpv_pkg::CFG_EDGE_CNT0],
                       cfg_reg[fpv_pkg::CFG_EDGE_EXT2], cfg_reg[fpv_pkg::CFG_EDGE_EXT1],
                       cfg_reg[fpv_pkg::CFG_EDGE_EXT0]};
    assign key_and  = &src.key_port;

    // edge select 1 = rising, 0 = falling
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_edge[i] = armed_reg && (edge_sel[i] ? (pin_now[i] && !pin_prev_reg[i])
                                                    : (!pin_now[i] && pin_prev_reg[i]));
        end
    end
    assign key_fall = armed_reg && key_prev_reg && !key_and;

    // sampled levels of edge inputs
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_prev_reg <= 5'h00;
            key_prev_reg <= 1'b0;
            armed_reg    <= 1'b0;
        end else begin
            pin_prev_reg <= pin_now;
            key_prev_reg <= key_and;
            armed_reg    <= 1'b1;
        end
    end

    // source selection: unselected sources raise nothing
    always_comb begin
        valid_src                      = '1;
        valid_src[fpv_pkg::SRC_EXT2]   = !cfg_reg[fpv_pkg::CFG_SEL_KEY];
        valid_src[fpv_pkg::SRC_KEY]    = cfg_reg[fpv_pkg::CFG_SEL_KEY];
        for (int t = 0; t < 4; t++) begin
            valid_src[fpv_pkg::SRC_TMR1 + t] = cfg_reg[fpv_pkg::CFG_SEL_TMR + t];
        end
        valid_src[fpv_pkg::SRC_S1RX]   = cfg_reg[fpv_pkg::CFG_SEL_S1];
        valid_src[fpv_pkg::SRC_S1TX]   = cfg_reg[fpv_pkg::CFG_SEL_S1];
        valid_src[fpv_pkg::SRC_S2RX]   = cfg_reg[fpv_pkg::CFG_SEL_S2];
        valid_src[fpv_pkg::SRC_S2TX]   = cfg_reg[fpv_pkg::CFG_SEL_S2];
        valid_src[fpv_pkg::SRC_TMRY]   = !cfg_reg[fpv_pkg::CFG_SEL_CNT1];
        valid_src[fpv_pkg::SRC_CNT1]   = cfg_reg[fpv_pkg::CFG_SEL_CNT1];
        valid_src[fpv_pkg::SRC_ADC]    = cfg_reg[fpv_pkg::CFG_SEL_ADC];
    end

    // raw source events in priority order
    always_comb begin
        ev                           = '0;
        ev[fpv_pkg::SRC_EXT0]        = pin_edge[0];
        ev[fpv_pkg::SRC_EXT1]        = pin_edge[1];
        ev[fpv_pkg::SRC_EXT2]        = pin_edge[2];
        ev[fpv_pkg::SRC_KEY]         = key_fall;
        ev[fpv_pkg::SRC_CNT0]        = pin_edge[3];
        ev[fpv_pkg::SRC_TMRX]        = src.tmrx_uf;
        for (int t = 0; t < 4; t++) begin
            ev[fpv_pkg::SRC_TMR1 + t] = src.tmr_uf[t];
        end
        ev[fpv_pkg::SRC_S1RX]        = src.s1_rx_done;
        ev[fpv_pkg::SRC_S1TX]        = src.s1_tx_done | src.s1_tx_empty;
        ev[fpv_pkg::SRC_S2RX]        = src.s2_rx_done;
        ev[fpv_pkg::SRC_S2TX]        = src.s2_tx_done | src.s2_tx_empty;
        ev[fpv_pkg::SRC_TMRY]        = src.tmry_uf;
        ev[fpv_pkg::SRC_CNT1]        = pin_edge[4];
        ev[fpv_pkg::SRC_ADC]         = src.adc_done;
        ev                           = ev & valid_src;
    end

    // pending = request, enable and selection; lowest index wins
    assign pend     = req_reg & ena_reg & valid_src;
    assign any_pend = |pend;
    always_comb begin
        win_onehot = '0;
        win_slot   = fpv_pkg::SLOT_BREAK;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_onehot = '0;
                win_onehot[i] = 1'b1;
                win_slot = fpv_pkg::SRC_SLOT[i*5 +: 5];
            end
        end
    end

    // acceptance only at an instruction boundary while idle
    assign take_mask = (st_reg == fpv_pkg::ST_IDLE) && cpu.instr_done && any_pend
                       && !stat_reg[fpv_pkg::STAT_DIS_BIT];
    // break ignores the flag but yields to a higher accepted source
    assign take_brk  = (st_reg == fpv_pkg::ST_IDLE) && cpu.instr_done && !take_mask
                       && (brk_pend_reg || cpu.software_break);

    // ahb: capture address phase, write in data phase
    assign ph_valid = hsel && hready && htrans[1];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (hready) begin
            ph_wr_reg   <= ph_valid && hwrite;
            ph_addr_reg <= haddr[7:0];
        end
    end
    assign wr_req = ph_wr_reg && (ph_addr_reg == fpv_pkg::OFF_REQ);
    assign wr_ena = ph_wr_reg && (ph_addr_reg == fpv_pkg::OFF_ENA);
    assign wr_cfg = ph_wr_reg && (ph_addr_reg == fpv_pkg::OFF_CFG);

    // read data registered at the address phase; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (ph_valid && !hwrite) begin
            case (haddr[7:0])
                fpv_pkg::OFF_REQ:  hrdata <= {15'h0000, req_reg};
                fpv_pkg::OFF_ENA:  hrdata <= {15'h0000, ena_reg};
                fpv_pkg::OFF_CFG:  hrdata <= {18'h00000, cfg_reg};
                fpv_pkg::OFF_STAT: hrdata <= {16'h0000, 3'h0, slot_reg,
                                              stat_reg};
                default:           hrdata <= 32'h00000000;
            endcase
        end
    end

    // request bits: events set even when disabled; set wins over any clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            req_reg <= '0;
        end else begin
            req_reg <= (req_reg
                        & ~(wr_req ? ~hwdata[N-1:0] : '0)
                        & ~(take_mask ? win_onehot : '0))
                       | ev;
        end
    end

    // enable bits and configuration
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ena_reg <= '0;
            cfg_reg <= fpv_pkg::CFG_RST;
        end else begin
            if (wr_ena) begin
                ena_reg <= hwdata[N-1:0];
            end
            if (wr_cfg) begin
                cfg_reg <= hwdata[fpv_pkg::CFG_W-1:0];
            end
        end
    end

    // break request held until its own acceptance
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            brk_pend_reg <= 1'b0;
        end else if (cpu.software_break && !take_brk) begin
            brk_pend_reg <= 1'b1;
        end else if (take_brk) begin
            brk_pend_reg <= 1'b0;
        end
    end

    // processor status: entry forces the flag only after the status push
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stat_reg <= fpv_pkg::STAT_RST;
        end else if (st_reg == fpv_pkg::ST_PUSH_STAT) begin
            stat_reg[fpv_pkg::STAT_DIS_BIT] <= 1'b1;
        end else if (cpu.return_from_interrupt) begin
            stat_reg <= cpu.ret_stat;
        end else if (cpu.set_disable_instr) begin
            stat_reg[fpv_pkg::STAT_DIS_BIT] <= 1'b1;
        end else if (cpu.clear_disable_instr) begin
            stat_reg[fpv_pkg::STAT_DIS_BIT] <= 1'b0;
        end else if (cpu.stat_wr) begin
            stat_reg <= cpu.stat_wdata;
        end
    end

    // entry sequencer; reset runs the same vector load as slot 1
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg   <= fpv_pkg::ST_RESET;
            slot_reg <= fpv_pkg::SLOT_RESET;
        end else begin
            case (st_reg)
                fpv_pkg::ST_RESET: st_reg <= fpv_pkg::ST_VEC;
                fpv_pkg::ST_IDLE: begin
                    if (take_mask) begin
                        st_reg   <= fpv_pkg::ST_PUSH_HI;
                        slot_reg <= win_slot;
                    end else if (take_brk) begin
                        st_reg   <= fpv_pkg::ST_PUSH_HI;
                        slot_reg <= fpv_pkg::SLOT_BREAK;
                    end
                end
                fpv_pkg::ST_PUSH_HI:   st_reg <= fpv_pkg::ST_PUSH_LO;
                fpv_pkg::ST_PUSH_LO:   st_reg <= fpv_pkg::ST_PUSH_STAT;
                fpv_pkg::ST_PUSH_STAT: st_reg <= fpv_pkg::ST_VEC;
                fpv_pkg::ST_VEC:   st_reg <= fpv_pkg::ST_IDLE;
                default:           st_reg <= fpv_pkg::ST_IDLE;
            endcase
        end
    end

    // vector of current slot: low byte address steps down two per slot
    assign vec_lo = fpv_pkg::VEC_TOP_LO - {10'h000, slot_reg - 5'h01, 1'b0};

    // registered outputs towards the cpu; pc is sampled while pushing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seq <= '0;
        end else begin
            seq.push_valid  <= 1'b0;
            seq.vec_valid   <= 1'b0;
            seq.slot        <= slot_reg;
            seq.vec_lo_addr <= vec_lo;
            seq.vec_hi_addr <= vec_lo + 16'h0001;
            case (st_reg)
                fpv_pkg::ST_PUSH_HI: begin
                    seq.push_valid <= 1'b1;
                    seq.push_data  <= cpu.pc[15:8];
                end
                fpv_pkg::ST_PUSH_LO: begin
                    seq.push_valid <= 1'b1;
                    seq.push_data  <= cpu.pc[7:0];
                end
                fpv_pkg::ST_PUSH_STAT: begin
                    seq.push_valid <= 1'b1;
                    seq.push_data  <= stat_reg;
                end
                fpv_pkg::ST_VEC: begin
                    seq.vec_valid  <= 1'b1;
                end
                default: begin
                    seq.push_data  <= seq.push_data;
                end
            endcase
        end
    end
endmodule : fpv_ctrl

/* src/fpv_pkg.sv */
// package: constants, types and register map of the vectored interrupt block
package fpv_pkg;
    // source index, ordered by priority; shared slots hold two adjacent entries
    localparam int NSRC       = 17;
    localparam int SRC_EXT0   = 0;
    localparam int SRC_EXT1   = 1;
    localparam int SRC_EXT2   = 2;
    localparam int SRC_KEY    = 3;
    localparam int SRC_CNT0   = 4;
    localparam int SRC_TMRX   = 5;
    localparam int SRC_TMR1   = 6;
    localparam int SRC_S1RX   = 10;
    localparam int SRC_S1TX   = 11;
    localparam int SRC_S2RX   = 12;
    localparam int SRC_S2TX   = 13;
    localparam int SRC_TMRY   = 14;
    localparam int SRC_CNT1   = 15;
    localparam int SRC_ADC    = 16;
    // priority slot of each source, slot 1 is reset and slot 17 the break
    localparam logic [NSRC*5-1:0] SRC_SLOT = {
        5'h10, 5'h0f, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09,
        5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h04, 5'h03, 5'h02};
    localparam logic [4:0]  SLOT_RESET = 5'h01;
    localparam logic [4:0]  SLOT_BREAK = 5'h11;
    // vector low byte of slot n is VEC_TOP_LO minus twice (n-1)
    localparam logic [15:0] VEC_TOP_LO = 16'hfffc;
    // processor status
    localparam int          STAT_DIS_BIT = 2;
    localparam logic [7:0]  STAT_RST     = 8'h04;
    // register byte offsets
    localparam logic [7:0]  OFF_REQ    = 8'h00;
    localparam logic [7:0]  OFF_ENA    = 8'h04;
    localparam logic [7:0]  OFF_CFG    = 8'h08;
    localparam logic [7:0]  OFF_STAT   = 8'h0c;
    // configuration field positions
    localparam int CFG_EDGE_EXT0  = 0;
    localparam int CFG_EDGE_EXT1  = 1;
    localparam int CFG_EDGE_EXT2  = 2;
    localparam int CFG_EDGE_CNT0  = 3;
    localparam int CFG_EDGE_CNT1  = 4;
    localparam int CFG_SEL_KEY    = 5;
    localparam int CFG_SEL_CNT1   = 6;
    localparam int CFG_SEL_TMR    = 7;
    localparam int CFG_SEL_S1     = 11;
    localparam int CFG_SEL_S2     = 12;
    localparam int CFG_SEL_ADC    = 13;
    localparam int CFG_W          = 14;
    localparam logic [CFG_W-1:0] CFG_RST = 14'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PUSH_HI   = 3'b001,
        ST_PUSH_LO   = 3'b011,
        ST_PUSH_STAT = 3'b010,
        ST_VEC   = 3'b110,
        ST_RESET = 3'b100
    } fpv_state_e;

    // requests from the cpu sequencer
    typedef struct packed {
        logic        instr_done;
        logic        set_disable_instr;
        logic        clear_disable_instr;
        logic        return_from_interrupt;
        logic        software_break;
        logic        stat_wr;
        logic [7:0]  stat_wdata;
        logic [7:0]  ret_stat;
        logic [15:0] pc;
    } fpv_cpu_s;

    // peripheral request sources
    typedef struct packed {
        logic        ext_irq_zero;
        logic        ext_irq_one;
        logic        ext_irq_two;
        logic        counter_input_zero;
        logic        counter_input_one;
        logic [7:0]  key_port;
        logic        tmrx_uf;
        logic [3:0]  tmr_uf;
        logic        s1_rx_done;
        logic        s1_tx_done;
        logic        s1_tx_empty;
        logic        s2_rx_done;
        logic        s2_tx_done;
        logic        s2_tx_empty;
        logic        tmry_uf;
        logic        adc_done;
    } fpv_src_s;

    // entry sequence towards the cpu
    typedef struct packed {
        logic        push_valid;
        logic [7:0]  push_data;
        logic        vec_valid;
        logic [15:0] vec_lo_addr;
        logic [15:0] vec_hi_addr;
        logic [4:0]  slot;
    } fpv_seq_s;
endpackage : fpv_pkg

/* tb/fpv_ctrl_asserts.sv */
// checker: entry sequence, vector address and disable flag relations
`timescale 1ns/1ps
module fpv_ctrl_asserts (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire fpv_pkg::fpv_cpu_s cpu,
    input wire fpv_pkg::fpv_seq_s seq,
    input wire logic [7:0]        processor_status
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // entry and reset vector shape
    reset_vec_a: assert property ($fell(sys_rst) |-> ##[1:2] (seq.vec_valid
        && seq.slot == 5'h01 && seq.vec_lo_addr == 16'hfffc && seq.vec_hi_addr == 16'hfffd))
        else $error("reset vector not issued");
    push_order_a: assert property ($rose(seq.push_valid) |-> ##1 seq.push_valid
        ##1 seq.push_valid ##1 (seq.vec_valid && !seq.push_valid))
        else $error("entry push order broken");
    vec_addr_a: assert property (seq.vec_valid |-> seq.vec_hi_addr == seq.vec_lo_addr + 16'h0001
        && seq.vec_lo_addr == 16'hfffc - {10'h000, seq.slot - 5'h01, 1'b0})
        else $error("vector address does not match slot");
    entry_gap_a: assert property (seq.vec_valid |=> !seq.push_valid)
        else $error("push too soon after vector");

    // flag handling around entry; maskable entries push a clear flag
    stat_push_a: assert property (seq.vec_valid && seq.slot != 5'h11 && seq.slot != 5'h01
        |-> !$past(seq.push_data[2])) else $error("status pushed with flag set");
    flag_entry_a: assert property (seq.vec_valid |-> processor_status[2])
        else $error("flag not set on entry");

    // flag instructions; the clear and return checks leave out cycles inside an entry, entry wins there
    set_flag_a: assert property (cpu.set_disable_instr && !cpu.return_from_interrupt
        |=> processor_status[2]) else $error("set-disable did not set flag");
    clear_flag_a: assert property (cpu.clear_disable_instr && !cpu.set_disable_instr
        && !cpu.return_from_interrupt && !$past(sys_rst) && !seq.push_valid && !seq.vec_valid
        |=> !processor_status[2]) else $error("clear-disable did not clear flag");
    ret_restore_a: assert property (cpu.return_from_interrupt && !$past(sys_rst)
        && !seq.push_valid && !seq.vec_valid |=> processor_status == $past(cpu.ret_stat))
        else $error("return did not restore status");

    cover property (seq.vec_valid && seq.slot == 5'h11);
    cover property (seq.vec_valid && seq.slot == 5'h10);
    cover property (cpu.return_from_interrupt);
endmodule : fpv_ctrl_asserts

bind fpv_ctrl fpv_ctrl_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .cpu(cpu), .seq(seq),
    .processor_status(processor_status));

/* tb/fpv_cpu_model.sv */
// cpu sequencer model: instruction boundaries, status stack, vector capture
`timescale 1ns/1ps
module fpv_cpu_model (
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic [3:0]        op,
    input wire fpv_pkg::fpv_seq_s seq,
    output fpv_pkg::fpv_cpu_s     cpu,
    output logic [23:0]           frame,
    output logic [36:0]           vec,
    output logic [7:0]            nvec
);
    logic tick_reg;

    // boundary every second cycle, as a multi-cycle core would give
    always_ff @(posedge mclk) begin
        if (sys_rst)
            tick_reg <= 1'b0;
        else
            tick_reg <= ~tick_reg;
    end

    // op bits: set-disable, clear-disable, break, return
    always_comb begin
        cpu = '0;
        cpu.instr_done = tick_reg;
        cpu.set_disable_instr = op[0];
        cpu.clear_disable_instr = op[1];
        cpu.software_break = op[2];
        cpu.return_from_interrupt = op[3];
        cpu.ret_stat = frame[7:0]; // pops what was stacked last
        cpu.pc = 16'hc35a;
    end

    // stack takes pc high, pc low, status in turn
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            frame <= '0;
            vec <= '0;
            nvec <= '0;
        end else begin
            if (seq.push_valid)
                frame <= {frame[15:0], seq.push_data};
            if (seq.vec_valid) begin
                vec <= {seq.slot, seq.vec_hi_addr, seq.vec_lo_addr};
                nvec <= nvec + 8'h01;
            end
        end
    end
endmodule : fpv_cpu_model

/* tb/tb.sv */
// testbench: sources, priorities, masking and flag handling
`timescale 1ns/1ps
module tb;
    logic              mclk;
    logic              sys_rst;
    logic              hsel;
    logic              hwrite;
    logic [1:0]        htrans;
    logic [31:0]       haddr;
    logic [31:0]       hwdata;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic [31:0]       rd;
    logic [3:0]        op;
    logic [23:0]       frame;
    logic [36:0]       vec;
    logic [7:0]        nvec;
    logic [7:0]        n0;
    logic [7:0]        processor_status;
    fpv_pkg::fpv_cpu_s cpu;
    fpv_pkg::fpv_seq_s seq;
    fpv_pkg::fpv_src_s src_in;
    int                n_fail;
    int                checks;
    localparam fpv_pkg::fpv_src_s IDLE = '{key_port: 8'hff, default: '0};
    // priority of each request bit, in request bit order
    localparam int PRI[17] = '{2, 3, 4, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 15, 16};

    fpv_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu(cpu), .src(src_in),
        .seq(seq), .processor_status(processor_status));
    fpv_cpu_model cpu_m (.mclk(mclk), .sys_rst(sys_rst), .op(op), .seq(seq), .cpu(cpu),
        .frame(frame), .vec(vec), .nvec(nvec));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one word transfer, then an idle cycle so a read never sees a stale write
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge mclk);
    endtask : bus

    task automatic do_op(input logic [3:0] v);
        op <= v;
        @(posedge mclk);
        op <= 4'h0;
        @(posedge mclk);
    endtask : do_op

    task automatic fire(input int i);
        fpv_pkg::fpv_src_s s;
        s = IDLE;
        case (i)
            0: s.ext_irq_zero = 1'b1;
            1: s.ext_irq_one = 1'b1;
            2: s.ext_irq_two = 1'b1;
            3: s.key_port = 8'hfe;
            4: s.counter_input_zero = 1'b1;
            5: s.tmrx_uf = 1'b1;
            6, 7, 8, 9: s.tmr_uf[i-6] = 1'b1;
            10: s.s1_rx_done = 1'b1;
            11: s.s1_tx_done = 1'b1;
            12: s.s2_rx_done = 1'b1;
            13: s.s2_tx_empty = 1'b1;
            14: s.tmry_uf = 1'b1;
            15: s.counter_input_one = 1'b1;
            default: s.adc_done = 1'b1;
        endcase
        src_in <= s;
        @(posedge mclk);
        src_in <= IDLE;
        @(posedge mclk);
    endtask : fire

    task automatic wait_vec(input logic [7:0] n);
        for (int k = 0; k < 60 && nvec === n; k++) @(posedge mclk);
        chk({24'h0, nvec}, {24'h0, n + 8'h01});
    endtask : wait_vec

    // one source from request to entry, handler clearing the flag first
    task automatic run(input int i);
        n0 = nvec;
        fire(i);
        do_op(4'h2);
        wait_vec(n0);
        chk({11'h0, vec[36:32], vec[15:0]}, (PRI[i] << 16) | (32'hfffc - 2 * (PRI[i] - 1)));
        chk({16'h0, vec[31:16]}, 32'hfffd - 2 * (PRI[i] - 1));
        chk({15'h0, frame[23:8], frame[2]}, {15'h0, 16'hc35a, 1'b0});
        chk({31'h0, processor_status[2]}, 32'h1);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
    endtask : run

    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        op = 4'h0;
        src_in = IDLE;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        wait_vec(8'h00);
        chk({11'h0, vec[36:32], vec[15:0]}, 32'h0001fffc);
        chk({8'h0, vec[31:16], processor_status}, 32'h00fffd04);
        // request bit sticks; software clears it but cannot set it
        bus(1'b1, 32'h4, 32'h1ffff);
        fire(5);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h20);
        bus(1'b1, 32'h0, 32'h1ffff);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h20);
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        // every source through its slot; shared slots need both selections
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, 32'h8, (p == 1) ? 32'h3fff : 32'h3f9f);
            bus(1'b1, 32'h0, 32'h0);
            for (int i = 0; i < 17; i++)
                if ((i == 3 || i == 15) == (p == 1)) run(i);
        end
        // unselected sharer of slot 4 stays silent
        bus(1'b1, 32'h8, 32'h3f9f);
        bus(1'b1, 32'h0, 32'h0);
        fire(3);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        // disabled source still posts its request but is not taken
        bus(1'b1, 32'h4, 32'h1ffdf);
        n0 = nvec;
        fire(5);
        do_op(4'h2);
        repeat (12) @(posedge mclk);
        chk({24'h0, nvec}, {24'h0, n0});
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h20);
        bus(1'b1, 32'h4, 32'h1ffff);
        wait_vec(n0);
        chk({27'h0, vec[36:32]}, 32'h6);
        // two pending: the higher wins, the other waits its turn
        n0 = nvec;
        fire(16);
        fire(1);
        do_op(4'h2);
        wait_vec(n0);
        chk({27'h0, vec[36:32]}, 32'h3);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h10000);
        n0 = nvec;
        do_op(4'h2);
        wait_vec(n0);
        chk({27'h0, vec[36:32]}, 32'h10);
        // break ignores the flag; return restores the stacked status
        do_op(4'h1);
        chk({31'h0, processor_status[2]}, 32'h1);
        n0 = nvec;
        do_op(4'h4);
        wait_vec(n0);
        chk({11'h0, vec[36:32], vec[15:0]}, 32'h0011ffdc);
        chk({31'h0, frame[2]}, 32'h1);
        do_op(4'h2);
        chk({31'h0, processor_status[2]}, 32'h0);
        do_op(4'h8);
        chk({24'h0, processor_status}, {24'h0, frame[7:0]});
        summarize();
    end
endmodule : tb
